// *** include/vocs_regs.vh ***
// Constants for the video output conditioner and serializer.
`ifndef VOCS_REGS_VH
`define VOCS_REGS_VH

// ----------------------------------------------------------------------
// Output formats
// ----------------------------------------------------------------------
`define VOCS_MODE_BAYER     3'h0
`define VOCS_MODE_YUV       3'h1
`define VOCS_MODE_RGB565    3'h2
`define VOCS_MODE_RGB444    3'h3
`define VOCS_MODE_RGB666    3'h4
`define VOCS_MODE_JPEG      3'h5

// ----------------------------------------------------------------------
// Frame strobe transfer units
// ----------------------------------------------------------------------
`define VOCS_UNIT_BYTE      2'h0
`define VOCS_UNIT_LINE      2'h1
`define VOCS_UNIT_IMAGE     2'h2

// ----------------------------------------------------------------------
// Reserved byte values and their substitutes
// ----------------------------------------------------------------------
`define VOCS_RSV_HIGH       8'hff
`define VOCS_RSV_LOW        8'h00
`define VOCS_NEAR_HIGH      8'hfe
`define VOCS_NEAR_LOW       8'h01
`define VOCS_565_1ST_HIGH   8'hf7
`define VOCS_565_1ST_LOW    8'h08
`define VOCS_444_1ST_HIGH   8'hef
`define VOCS_444_1ST_LOW    8'h10
`define VOCS_444_2ND_HIGH   8'hf0

// ----------------------------------------------------------------------
// Serial word and timing
// ----------------------------------------------------------------------
`define VOCS_WORD_BITS      8
`define VOCS_FIFO_DEPTH     8
`define VOCS_CLK_MHZ        10
`define VOCS_SCLK_HALF_NS   200
`define VOCS_SCLK_HALF_CYC  ((`VOCS_SCLK_HALF_NS*`VOCS_CLK_MHZ+999)/1000)

`endif

// *** verilog/vocs_serializer.v ***
// Pixel byte conditioner, output FIFO and serial video transmitter.
`timescale 1ns/1ps
`default_nettype none
`include "vocs_regs.vh"


// ----------------------------------------------------------------------
// Output FIFO
// ----------------------------------------------------------------------
module vocs_fifo #(
    parameter W     = 10,
    parameter DEPTH = `VOCS_FIFO_DEPTH,
    parameter AW    = 3
) (
    input  wire         i_ref_clk,
    input  wire         i_rst_b,
    input  wire [W-1:0] i_wr_data,
    input  wire         i_wr_valid,
    output reg          o_wr_ready,
    output wire [W-1:0] o_rd_data,
    output reg          o_rd_valid,
    input  wire         i_rd_ready
);
    localparam [31:0]   LAST_W = DEPTH - 1;
    localparam [31:0]   FULL_W = DEPTH;
    localparam [AW-1:0] LAST  = LAST_W[AW-1:0];
    localparam [AW:0]   FULLC = FULL_W[AW:0];
    localparam [AW:0]   ONE   = {{AW{1'b0}}, 1'b1};

    reg  [W-1:0]  mem [0:DEPTH-1];
    reg  [AW-1:0] wp;
    reg  [AW-1:0] rp;
    reg  [AW:0]   cnt;
    reg  [AW:0]   next_cnt;
    wire          wr = i_wr_valid & o_wr_ready;
    wire          rd = i_rd_ready & o_rd_valid;

    assign o_rd_data = mem[rp];

    always @* begin
        next_cnt = cnt;
        if (wr & ~rd) begin
            next_cnt = cnt + ONE;
        end else if (rd & ~wr) begin
            next_cnt = cnt - ONE;
        end
    end

    // The array has no reset so that it can map onto plain storage.
    always @(posedge i_ref_clk) begin
        if (wr) begin
            mem[wp] <= i_wr_data;
        end
    end

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wp         <= {AW{1'b0}};
            rp         <= {AW{1'b0}};
            cnt        <= {(AW+1){1'b0}};
            o_wr_ready <= 1'b1;
            o_rd_valid <= 1'b0;
        end else begin
            if (wr) begin
                wp <= (wp == LAST) ? {AW{1'b0}} : wp + 1'b1;
            end
            if (rd) begin
                rp <= (rp == LAST) ? {AW{1'b0}} : rp + 1'b1;
            end
            cnt        <= next_cnt;
            // Both flags come from the next count, so they never lag a
            // write or a read and the ports stay plain flop outputs.
            o_wr_ready <= (next_cnt != FULLC);
            o_rd_valid <= (next_cnt != {(AW+1){1'b0}});
        end
    end
endmodule // vocs_fifo

// ----------------------------------------------------------------------
// Conditioner and serial transmitter
// ----------------------------------------------------------------------
module vocs_serializer #(
    parameter HALF_CYC = `VOCS_SCLK_HALF_CYC,
    parameter DEPTH    = `VOCS_FIFO_DEPTH
) (
    input  wire       i_ref_clk,
    input  wire       i_rst_b,
    input  wire       i_markers_en,
    input  wire [2:0] i_out_mode,
    input  wire       i_ssi_mode,
    input  wire [1:0] i_frame_unit,
    input  wire       i_strobe_hold,
    input  wire       i_clk_continuous,
    input  wire       i_clk_2x,
    input  wire [7:0] i_pix_data,
    input  wire       i_pix_second,
    input  wire       i_pix_line_end,
    input  wire       i_pix_frame_end,
    input  wire       i_pix_valid,
    output wire       o_pix_ready,
    output reg        o_serial_out_clock,
    output reg        o_serial_out_line,
    output reg        o_serial_frame_strobe,
    output reg        o_busy
);
    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_STROBE = 2'h1;
    localparam [1:0] ST_SHIFT  = 2'h2;
    localparam [31:0] DIV_W    = HALF_CYC - 1;
    localparam [31:0] BIT_W    = `VOCS_WORD_BITS - 1;
    localparam [7:0]  DIV_LAST = DIV_W[7:0];
    localparam [2:0]  BIT_LAST = BIT_W[2:0];

    // ------------------------------------------------------------------
    // Marker emulation guard
    // ------------------------------------------------------------------
    function [7:0] clamp;
        input [7:0] d;
        input [7:0] hi;
        input [7:0] lo;
        begin
            if (d == `VOCS_RSV_HIGH) begin
                clamp = hi;
            end else if (d == `VOCS_RSV_LOW) begin
                clamp = lo;
            end else begin
                clamp = d;
            end
        end
    endfunction

    function [7:0] condition;
        input [2:0] mode;
        input       second;
        input [7:0] d;
        begin
            case (mode)
                `VOCS_MODE_BAYER: begin
                    condition = clamp(d, `VOCS_NEAR_HIGH,
                                      `VOCS_NEAR_LOW);
                end
                `VOCS_MODE_RGB666: begin
                    condition = clamp(d, `VOCS_NEAR_HIGH,
                                      `VOCS_NEAR_LOW);
                end
                `VOCS_MODE_RGB565: begin
                    if (second) begin
                        condition = clamp(d, `VOCS_NEAR_HIGH,
                                          `VOCS_NEAR_LOW);
                    end else begin
                        condition = clamp(d, `VOCS_565_1ST_HIGH,
                                          `VOCS_565_1ST_LOW);
                    end
                end
                `VOCS_MODE_RGB444: begin
                    if (second) begin
                        condition = clamp(d, `VOCS_444_2ND_HIGH,
                                          `VOCS_NEAR_LOW);
                    end else begin
                        condition = clamp(d, `VOCS_444_1ST_HIGH,
                                          `VOCS_444_1ST_LOW);
                    end
                end
                `VOCS_MODE_YUV: begin
                    condition = d;
                end
                default: begin
                    // JPEG and ancillary bytes are not told apart.
                    condition = d;
                end
            endcase
        end
    endfunction

    // Tells whether the byte just sent closes the current strobe unit.
    function unit_end;
        input [1:0] unit;
        input       line_end;
        input       frame_end;
        begin
            case (unit)
                `VOCS_UNIT_BYTE:  unit_end = 1'b1;
                `VOCS_UNIT_LINE:  unit_end = line_end;
                `VOCS_UNIT_IMAGE: unit_end = frame_end;
                default:          unit_end = 1'b1;
            endcase
        end
    endfunction

    // Conditioning happens before the FIFO, so the stored byte is final.
    wire [7:0] cond_data = i_markers_en ?
        condition(i_out_mode, i_pix_second, i_pix_data) : i_pix_data;

    // ------------------------------------------------------------------
    // Output FIFO
    // ------------------------------------------------------------------
    wire [9:0] fifo_data;
    wire       fifo_valid;
    wire       pop;

    vocs_fifo #(
        .W     (10),
        .DEPTH (DEPTH),
        .AW    (3)
    ) u_fifo (
        .i_ref_clk  (i_ref_clk),
        .i_rst_b    (i_rst_b),
        .i_wr_data  ({i_pix_frame_end, i_pix_line_end, cond_data}),
        .i_wr_valid (i_pix_valid),
        .o_wr_ready (o_pix_ready),
        .o_rd_data  (fifo_data),
        .o_rd_valid (fifo_valid),
        .i_rd_ready (pop)
    );

    // ------------------------------------------------------------------
    // Serial clock divider
    // ------------------------------------------------------------------
    // The divider runs free, so serial edges always sit on one grid, and a
    // gated clock restarts on the first tick at which run_clk is high again.
    reg  [7:0] div_cnt;
    wire       tick = (div_cnt == DIV_LAST);

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Transmit sequencer
    // ------------------------------------------------------------------
    reg  [1:0] state;
    reg  [1:0] next_state;
    reg        sub;
    reg  [7:0] shreg;
    reg  [2:0] bitcnt;
    reg        cur_line_end;
    reg        cur_frame_end;
    reg        unit_start;

    // A data bit boundary is a rising serial edge; in 2X mode only
    // every second rising edge carries a new bit.
    wire rise     = tick & ~o_serial_out_clock;
    wire bit_edge = rise & (~i_clk_2x | sub);
    wire last_bit = (bitcnt == 3'h0);
    // A new strobe is needed for every byte, or at the start of a unit.
    wire need_frm = i_ssi_mode &
        ((i_frame_unit == `VOCS_UNIT_BYTE) | unit_start);
    wire cur_done = unit_end(i_frame_unit, cur_line_end, cur_frame_end);
    wire ready_ld = (state == ST_IDLE) |
        ((state == ST_SHIFT) & last_bit);

    assign pop = bit_edge & fifo_valid &
        ((state == ST_STROBE) | (ready_ld & ~need_frm));

    always @* begin
        next_state = state;
        if (bit_edge) begin
            case (state)
                ST_IDLE: begin
                    if (fifo_valid) begin
                        next_state = need_frm ? ST_STROBE : ST_SHIFT;
                    end
                end
                ST_STROBE: begin
                    next_state = ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (last_bit) begin
                        if (!fifo_valid) begin
                            next_state = ST_IDLE;
                        end else if (need_frm) begin
                            next_state = ST_STROBE;
                        end
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // Gating only ever stops the clock while it is low, so the receiver
    // never sees a runt high phase.
    wire run_clk = (next_state != ST_IDLE) |
        (i_ssi_mode & i_clk_continuous);

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state                 <= ST_IDLE;
            sub                   <= 1'b0;
            shreg                 <= 8'h00;
            bitcnt                <= 3'h0;
            cur_line_end          <= 1'b0;
            cur_frame_end         <= 1'b0;
            unit_start            <= 1'b1;
            o_serial_out_clock    <= 1'b0;
            o_serial_out_line     <= 1'b0;
            o_serial_frame_strobe <= 1'b0;
            o_busy                <= 1'b0;
        end else begin
            state  <= next_state;
            o_busy <= (next_state != ST_IDLE) | fifo_valid;
            if (tick) begin
                if (o_serial_out_clock) begin
                    o_serial_out_clock <= 1'b0;
                end else begin
                    o_serial_out_clock <= run_clk;
                    sub                <= i_clk_2x & ~sub;
                end
            end
            if (bit_edge) begin
                if (pop) begin
                    // Load drives the MSB on this rising edge.
                    shreg             <= {fifo_data[6:0], 1'b0};
                    o_serial_out_line <= fifo_data[7];
                    bitcnt            <= BIT_LAST;
                    cur_line_end      <= fifo_data[8];
                    cur_frame_end     <= fifo_data[9];
                    unit_start <= unit_end(i_frame_unit, fifo_data[8],
                                           fifo_data[9]);
                    if (!i_strobe_hold) begin
                        o_serial_frame_strobe <= 1'b0;
                    end
                end else if (next_state == ST_STROBE) begin
                    o_serial_frame_strobe <= 1'b1;
                    o_serial_out_line     <= 1'b0;
                end else if ((state == ST_SHIFT) & ~last_bit) begin
                    o_serial_out_line <= shreg[7];
                    shreg             <= {shreg[6:0], 1'b0};
                    bitcnt            <= bitcnt - 3'h1;
                end else if (state == ST_SHIFT) begin
                    o_serial_out_line <= 1'b0;
                end
                if ((state == ST_SHIFT) & last_bit & cur_done &
                    (next_state != ST_STROBE)) begin
                    o_serial_frame_strobe <= 1'b0;
                end
            end
        end
    end
endmodule // vocs_serializer

`default_nettype wire

// *** dv/vocs_serializer_checker.sv ***
// Concurrent checks on the serial side of the transmitter.
`timescale 1ns/1ps
`default_nettype none
module vocs_serializer_checker #(
    parameter HALF_CYC = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_ssi_mode,
    input wire logic i_strobe_hold,
    input wire logic i_clk_continuous,
    input wire logic i_clk_2x,
    input wire logic o_serial_out_clock,
    input wire logic o_serial_out_line,
    input wire logic o_serial_frame_strobe,
    input wire logic o_busy
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // ------------------------------------------------------------------
    // Serial clock edge spacing
    // ------------------------------------------------------------------
    // Saturating, so that a long gated pause cannot wrap into a false gap.
    logic       prev_clk;
    logic       seen;
    logic [9:0] since;
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prev_clk <= 1'b0;
            seen     <= 1'b0;
            since    <= 10'h000;
        end else begin
            prev_clk <= o_serial_out_clock;
            if (o_serial_out_clock != prev_clk) begin
                seen  <= 1'b1;
                since <= 10'h000;
            end else if (since != 10'h3ff) begin
                since <= since + 10'h001;
            end
        end
    end
    property p_half_period;
        seen && since != 10'h3ff && o_serial_out_clock != prev_clk
            |-> ((since + 1) % HALF_CYC) == 0;
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("serial clock edge off the divider grid");
    property p_idle_low;
        (!o_busy && !i_clk_continuous) [*4] |-> !o_serial_out_clock;
    endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("serial clock not low while idle");
    property p_hold_high;
        o_serial_out_clock && $past(o_serial_out_clock)
            |-> $stable(o_serial_out_line);
    endproperty
    a_hold_high: assert property (p_hold_high)
        else $error("data moved while serial clock high");
    property p_hold_fall;
        $fell(o_serial_out_clock)
            |-> $stable(o_serial_out_line) && $stable(o_serial_frame_strobe);
    endproperty
    a_hold_fall: assert property (p_hold_fall)
        else $error("data or strobe moved at the sampling edge");
    property p_gated;
        !i_ssi_mode && $changed(o_serial_out_clock) |-> o_busy || $past(o_busy);
    endproperty
    a_gated: assert property (p_gated)
        else $error("serial clock toggled with nothing to send");
    property p_no_strobe;
        !i_ssi_mode |-> !o_serial_frame_strobe;
    endproperty
    a_no_strobe: assert property (p_no_strobe)
        else $error("strobe raised in clock-qualified mode");
    property p_strobe_lead;
        $rose(o_serial_frame_strobe)
            |-> $rose(o_serial_out_clock) && !o_serial_out_line;
    endproperty
    a_strobe_lead: assert property (p_strobe_lead)
        else $error("strobe not aligned to a leading idle period");
    property p_pulse_width;
        HALF_CYC == 4 && !i_clk_2x && !i_strobe_hold
            && $rose(o_serial_frame_strobe)
            |-> o_serial_frame_strobe [*8] ##1 !o_serial_frame_strobe;
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("strobe pulse not one serial period");
    c_strobe: cover property ($rose(o_serial_frame_strobe));
    c_held: cover property (i_strobe_hold && $fell(o_serial_frame_strobe));
    c_two_x: cover property (i_clk_2x && $rose(o_serial_out_clock));
endmodule // vocs_serializer_checker
bind vocs_serializer vocs_serializer_checker #(.HALF_CYC(HALF_CYC)) chk_u (
    .i_ref_clk            (i_ref_clk),
    .i_rst_b              (i_rst_b),
    .i_ssi_mode           (i_ssi_mode),
    .i_strobe_hold        (i_strobe_hold),
    .i_clk_continuous     (i_clk_continuous),
    .i_clk_2x             (i_clk_2x),
    .o_serial_out_clock   (o_serial_out_clock),
    .o_serial_out_line    (o_serial_out_line),
    .o_serial_frame_strobe(o_serial_frame_strobe),
    .o_busy               (o_busy)
);
`default_nettype wire

// *** dv/vocs_rx_model.sv ***
// Behavioural serial receiver standing at the far end of the link.
`timescale 1ns/1ps
`default_nettype none
module vocs_rx_model (
    input  wire logic       i_rst_b,
    input  wire logic       i_serial_out_clock,
    input  wire logic       i_serial_out_line,
    input  wire logic       i_serial_frame_strobe,
    input  wire logic       i_framed,
    input  wire logic       i_byte_unit,
    input  wire logic       i_two_x,
    output var  logic [7:0] o_byte,
    output var  logic       o_got
);
    logic [7:0] shift;
    int         nbit;
    logic       active;
    logic       odd;
    always @(negedge i_serial_out_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            nbit = 0;
            active = 1'b0;
            odd = 1'b0;
            o_got = 1'b0;
            o_byte = 8'h00;
        end else if (i_two_x && odd) begin
            odd = 1'b0;
        end else begin
            odd = i_two_x;
            if (i_framed && !active) begin
                active = i_serial_frame_strobe;
            end else begin
                shift = {shift[6:0], i_serial_out_line};
                nbit++;
                if (nbit == 8) begin
                    o_byte = shift;
                    o_got = ~o_got;
                    nbit = 0;
                    // Line and image units run on without a new strobe.
                    if (i_byte_unit) active = 1'b0;
                end
            end
        end
    end
endmodule // vocs_rx_model
`default_nettype wire

// *** dv/vocs_serializer_bench.sv ***
// Self-checking bench for the conditioner and serial transmitter.
`timescale 1ns/1ps
`default_nettype none
module vocs_serializer_bench;
    logic       clk, rst_b, prst_b, mk, ssi, hold, cont, x2, sec, le, vld;
    logic [2:0] mode;
    logic [1:0] unit;
    logic [7:0] din;
    logic       last_sclk;
    wire        ready, sclk, sdat, sfrm, busy, got;
    wire  [7:0] rx_byte;
    logic [7:0] exp_q[$];
    logic [7:0] rx_q[$];
    int         n_mismatch, num_checks, n_rise, n_strb, n_full, n_cyc;

    vocs_serializer #(.HALF_CYC(4)) dut_u (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_markers_en(mk),
        .i_out_mode(mode), .i_ssi_mode(ssi), .i_frame_unit(unit),
        .i_strobe_hold(hold), .i_clk_continuous(cont), .i_clk_2x(x2),
        .i_pix_data(din), .i_pix_second(sec), .i_pix_line_end(le),
        .i_pix_frame_end(le), .i_pix_valid(vld), .o_pix_ready(ready),
        .o_serial_out_clock(sclk), .o_serial_out_line(sdat),
        .o_serial_frame_strobe(sfrm), .o_busy(busy));
    vocs_rx_model rx_u (
        .i_rst_b(prst_b), .i_serial_out_clock(sclk),
        .i_serial_out_line(sdat), .i_serial_frame_strobe(sfrm),
        .i_framed(ssi), .i_byte_unit(unit == 2'h0), .i_two_x(x2),
        .o_byte(rx_byte), .o_got(got));

    always @(got) if (prst_b === 1'b1) rx_q.push_back(rx_byte);
    // Sampled on the falling edge, where every registered output is settled.
    always @(negedge clk) begin
        n_cyc++;
        if (sclk === 1'b1 && last_sclk === 1'b0) n_rise++;
        if (sfrm === 1'b1) n_strb++;
        if (ready === 1'b0) n_full++;
        last_sclk = sclk;
        if (n_cyc > 30000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] exp_byte(input logic k,
        input logic [2:0] m, input logic s, input logic [7:0] d);
        logic [15:0] sub;
        case ({m, s})
            4'h4: sub = 16'hf708;
            4'h6: sub = 16'hef10;
            4'h7: sub = 16'hf001;
            default: sub = 16'hfe01;
        endcase
        if (!k || m == 3'h1 || m == 3'h5 || (d != 8'hff && d != 8'h00))
            return d;
        return (d == 8'hff) ? sub[15:8] : sub[7:0];
    endfunction
    // Changes the set-up only while the link is idle.
    task automatic cfg(input logic s, input logic [1:0] u, input logic h,
                       input logic c, input logic x);
        @(negedge clk);
        ssi = s; unit = u; hold = h; cont = c; x2 = x; prst_b = 1'b0;
        repeat (4) @(negedge clk);
        prst_b = 1'b1; n_rise = 0; n_strb = 0;
    endtask
    // Leaves the request up so that back-to-back bytes never drop it between writes.
    task automatic send(input logic [7:0] d, input logic s, input logic l,
                        input logic [7:0] e);
        din = d; sec = s; le = l; vld = 1'b1;
        exp_q.push_back(e);
        while (ready !== 1'b1) @(negedge clk);
        @(negedge clk);
    endtask
    task automatic drain;
        int quiet;
        vld = 1'b0;
        quiet = 0;
        while (quiet < 20) begin
            @(negedge clk);
            quiet = (busy === 1'b0) ? quiet + 1 : 0;
        end
        check(rx_q.size(), exp_q.size());
        while (exp_q.size() > 0 && rx_q.size() > 0)
            check(rx_q.pop_front(), exp_q.pop_front());
        exp_q.delete();
        rx_q.delete();
    endtask

    task automatic t_clamp;
        logic [7:0] d;
        cfg(1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
        for (int m = 0; m < 12; m++) begin
            mk = m[0];
            mode = m[3:1];
            for (int j = 0; j < 6; j++) begin
                d = (j % 3 == 0) ? 8'h00 : (j % 3 == 1) ? 8'hff : 8'h5a;
                send(d, j >= 3, 1'b0, exp_byte(mk, mode, j >= 3, d));
            end
            drain();
        end
        check(n_rise, 72 * 8);
    endtask
    task automatic t_anc;
        logic [7:0] pk [0:10] = '{8'h00, 8'hff, 8'hff, 8'h3c, 8'h5a, 8'h01,
                                  8'h00, 8'hff, 8'h10, 8'h80, 8'hc5};
        cfg(1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
        mk = 1'b1;
        mode = 3'h5;
        n_full = 0;
        for (int i = 0; i < 11; i++) send(pk[i], 1'b0, 1'b0, pk[i]);
        check(n_full > 0, 1);
        drain();
    endtask
    task automatic t_two_x;
        cfg(1'b0, 2'h0, 1'b0, 1'b0, 1'b1);
        mode = 3'h0;
        send(8'h00, 1'b0, 1'b0, 8'h01);
        send(8'hc3, 1'b0, 1'b0, 8'hc3);
        send(8'hff, 1'b0, 1'b0, 8'hfe);
        drain();
        check(n_rise, 48);
    endtask
    task automatic t_byte;
        cfg(1'b1, 2'h0, 1'b0, 1'b0, 1'b0);
        mode = 3'h5;
        send(8'ha5, 1'b0, 1'b0, 8'ha5);
        send(8'h81, 1'b0, 1'b0, 8'h81);
        send(8'h3e, 1'b0, 1'b0, 8'h3e);
        drain();
        check(n_strb, 24);
        check(n_rise, 27);
    endtask
    task automatic t_unit;
        for (int u = 1; u < 3; u++) begin
            cfg(1'b1, u[1:0], 1'b1, 1'b0, 1'b0);
            for (int i = 0; i < 4; i++)
                send(8'h96 + i[7:0], 1'b0, i == 3, 8'h96 + i[7:0]);
            drain();
            check(n_strb, 264);
            check(n_rise, 33);
        end
    endtask
    task automatic t_cont;
        int r;
        cfg(1'b1, 2'h0, 1'b0, 1'b0, 1'b0);
        @(posedge clk) r = n_rise;
        repeat (80) @(posedge clk);
        check(n_rise - r, 0);
        cfg(1'b1, 2'h0, 1'b0, 1'b1, 1'b0);
        @(posedge clk) r = n_rise;
        repeat (80) @(posedge clk);
        check(n_rise - r, 10);
    endtask

    initial forever #50 clk = ~clk;
    initial begin
        clk = 1'b0; rst_b = 1'b0; prst_b = 1'b0; mk = 1'b0; mode = 3'h0;
        ssi = 1'b0; unit = 2'h0; hold = 1'b0; cont = 1'b0; x2 = 1'b0;
        din = 8'h00; sec = 1'b0; le = 1'b0; vld = 1'b0; last_sclk = 1'b0;
        n_mismatch = 0; num_checks = 0; n_rise = 0; n_strb = 0;
        n_full = 0; n_cyc = 0;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        t_clamp();
        t_anc();
        t_two_x();
        t_byte();
        t_unit();
        t_cont();
        complete_run();
    end
endmodule // vocs_serializer_bench
`default_nettype wire
